// ### inc/ptmc_defines.vh
// Function
// RULE1 - Two identical timers, own counter, comparators, pins.
// RULE2 - Compare match interrupts, may clear counter, drive output.
// RULE3 - Clock from system, high, sub or pin.
// RULE4 - Separate interrupts for comparator A and P.
// RULE5 - External clock edge rising or falling.
// RULE6 - External clock pin triggers single pulse.
// RULE7 - Capture on rising, falling or both edges.
// RULE8 - External clock pin selectable as capture source.
// RULE9 - Inverted output is complement of primary output.
// RULE10 - Compare match sets, clears or toggles output.
// RULE11 - Output pins carry PWM waveform in PWM mode.
// RULE12 - One edge-aligned PWM, duty or period adjustable.
// RULE13 - Software routes pin sharing before using outputs.
// RULE14 - Ten-bit values split; low byte via holding buffer.
// RULE15 - Buffer moves only on high byte access.
// RULE16 - Compare low write updates holding buffer only.
// RULE17 - Compare high write loads high and buffer atomically.
// RULE18 - High byte read snapshots low byte into buffer.
// RULE19 - Low byte read returns holding buffer.
// RULE20 - Software writes low first, reads high first.
// RULE21 - Ten-bit up-counter clears on overflow or match.
// RULE22 - Clock select encoding of three bits.
// RULE23 - Mode field encoding of two bits.
// RULE24 - On rising clears counter; off holds count.
// RULE25 - Pin inputs synchronised and edge detected once.
`ifndef PTMC_DEFINES_VH
`define PTMC_DEFINES_VH
`define PTMC_ADDR_W 4
`define PTMC_OFS_CTRL0 4'h0
`define PTMC_OFS_CTRL1 4'h1
`define PTMC_OFS_CNT_LO 4'h2
`define PTMC_OFS_CNT_HI 4'h3
`define PTMC_OFS_CMPA_LO 4'h4
`define PTMC_OFS_CMPA_HI 4'h5
`define PTMC_OFS_CMPP_LO 4'h6
`define PTMC_OFS_CMPP_HI 4'h7
`define PTMC_OFS_STATUS 4'h8
`define PTMC_INST_SEL_BIT 3
`define PTMC_INST_STRIDE 5'h10
`define PTMC_C0_PAUSE 7
`define PTMC_C0_CK_HI 6
`define PTMC_C0_CK_LO 4
`define PTMC_C0_ON 3
`define PTMC_C1_MODE_HI 7
`define PTMC_C1_MODE_LO 6
`define PTMC_C1_IO_HI 5
`define PTMC_C1_IO_LO 4
`define PTMC_C1_OC 3
`define PTMC_C1_POL 2
`define PTMC_C1_CAPTS 1
`define PTMC_C1_CCLR 0
`define PTMC_C0_MASK 8'hF8
`define PTMC_CK_SYS_DIV4 3'h0
`define PTMC_CK_SYS 3'h1
`define PTMC_CK_HI_DIV16 3'h2
`define PTMC_CK_HI_DIV64 3'h3
`define PTMC_CK_SUB_A 3'h4
`define PTMC_CK_SUB_B 3'h5
`define PTMC_CK_PIN_RISE 3'h6
`define PTMC_CK_PIN_FALL 3'h7
`define PTMC_MODE_CMP 2'h0
`define PTMC_MODE_CAP 2'h1
`define PTMC_MODE_PWM 2'h2
`define PTMC_MODE_TMR 2'h3
`define PTMC_IO_PWM_OUT 2'h2
`define PTMC_IO_SINGLE 2'h3
`define PTMC_DIV4 8'h03
`define PTMC_DIV16 8'h0F
`define PTMC_DIV64 8'h3F
`define PTMC_CNT_MAX 10'h3FF
`endif

// ### logic/ptmc_unit.v
// Design decisions made here: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "ptmc_defines.vh"
module ptmc_unit (
    // Clock and reset
    input wire ref_clk_i,
    input wire resetn_i,
    // Shared ticks and pins (pins already synchronised)
    input wire tick_div4_i,
    input wire tick_h16_i,
    input wire tick_h64_i,
    input wire tick_sub_i,
    input wire ext_clk_sync_i,
    input wire cap_sync_i,
    // Register port
    input wire [2:0] reg_addr_i,
    input wire [7:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [7:0] rdata_o,
    // Outputs
    output reg out_o,
    output reg out_inv_o,
    output reg irq_a_o,
    output reg irq_p_o
);
    reg [7:0] ctrl0_q;
    reg [7:0] ctrl1_q;
    reg [9:0] count_q;
    reg [9:0] cmp_a_q;
    reg [9:0] cmp_p_q;
    reg [7:0] hold_q;
    reg on_q;
    reg ext_prev_q;
    reg cap_prev_q;
    reg pulse_run_q;
    reg [7:0] rd_q;
    wire [2:0] ck_sel = ctrl0_q[`PTMC_C0_CK_HI:`PTMC_C0_CK_LO];
    wire [1:0] mode = ctrl1_q[`PTMC_C1_MODE_HI:`PTMC_C1_MODE_LO]; // [RULE23]
    wire [1:0] io = ctrl1_q[`PTMC_C1_IO_HI:`PTMC_C1_IO_LO];
    wire oc = ctrl1_q[`PTMC_C1_OC];
    wire on_now = ctrl0_q[`PTMC_C0_ON];
    wire on_rise = on_now & ~on_q;
    wire ext_rise = ext_clk_sync_i & ~ext_prev_q; // [RULE25]
    wire ext_fall = ~ext_clk_sync_i & ext_prev_q; // [RULE25]
    wire cap_in = ctrl1_q[`PTMC_C1_CAPTS] ? ext_clk_sync_i : cap_sync_i; // [RULE8]
    wire cap_prev = ctrl1_q[`PTMC_C1_CAPTS] ? ext_prev_q : cap_prev_q;
    reg tick;
    reg cap_ev;
    always @* begin
        case (ck_sel) // [RULE3] [RULE22]
            `PTMC_CK_SYS_DIV4: tick = tick_div4_i;
            `PTMC_CK_SYS: tick = 1'b1;
            `PTMC_CK_HI_DIV16: tick = tick_h16_i;
            `PTMC_CK_HI_DIV64: tick = tick_h64_i;
            `PTMC_CK_SUB_A, `PTMC_CK_SUB_B: tick = tick_sub_i;
            `PTMC_CK_PIN_RISE: tick = ext_rise; // [RULE5]
            default: tick = ext_fall; // [RULE5]
        endcase
        case (io) // [RULE7]
            2'h0: cap_ev = cap_in & ~cap_prev;
            2'h1: cap_ev = ~cap_in & cap_prev;
            2'h2: cap_ev = cap_in ^ cap_prev;
            default: cap_ev = 1'b0;
        endcase
    end
    // Single pulse waits for its trigger; other modes count whenever on and not paused.
    wire single = (mode == `PTMC_MODE_PWM) && (io == `PTMC_IO_SINGLE);
    wire run = on_now & ~ctrl0_q[`PTMC_C0_PAUSE] & (~single | pulse_run_q)
               & (mode != `PTMC_MODE_CAP);
    wire cnt_tick = run & tick;
    wire match_a = cnt_tick && (count_q == cmp_a_q); // [RULE2]
    wire match_p = cnt_tick && (count_q == cmp_p_q); // [RULE2]
    wire clr_a = match_a & ctrl1_q[`PTMC_C1_CCLR];
    wire clr_p = match_p & ~ctrl1_q[`PTMC_C1_CCLR];
    wire ovf = cnt_tick && (count_q == `PTMC_CNT_MAX);
    always @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctrl0_q <= 8'h00;
            ctrl1_q <= 8'h00;
            count_q <= 10'h000;
            cmp_a_q <= 10'h000;
            cmp_p_q <= 10'h000;
            hold_q <= 8'h00;
            on_q <= 1'b0;
            ext_prev_q <= 1'b0;
            cap_prev_q <= 1'b0;
            pulse_run_q <= 1'b0;
            out_o <= 1'b0;
            out_inv_o <= 1'b1;
            irq_a_o <= 1'b0;
            irq_p_o <= 1'b0;
            rdata_o <= 8'h00;
        end else begin
            on_q <= on_now;
            ext_prev_q <= ext_clk_sync_i;
            cap_prev_q <= cap_sync_i;
            irq_a_o <= match_a; // [RULE4]
            irq_p_o <= match_p; // [RULE4]
            if (on_rise) begin
                count_q <= 10'h000; // [RULE24]
            end else if (on_now && mode == `PTMC_MODE_CAP) begin
                if (cap_ev && !ctrl0_q[`PTMC_C0_PAUSE]) begin
                    cmp_a_q <= count_q;
                end
                if (!ctrl0_q[`PTMC_C0_PAUSE] && tick) begin
                    count_q <= (count_q == cmp_p_q) ? 10'h000 : count_q + 10'h001;
                end
            end else if (clr_a || clr_p || ovf) begin
                count_q <= 10'h000; // [RULE21] [RULE2]
            end else if (cnt_tick) begin
                count_q <= count_q + 10'h001; // [RULE21]
            end
            if (single && on_now && ext_rise) begin
                pulse_run_q <= 1'b1; // [RULE6]
            end else if (!on_now || (single && (match_p || ovf))) begin
                pulse_run_q <= 1'b0;
            end
            if (on_rise && mode != `PTMC_MODE_CAP && mode != `PTMC_MODE_TMR) begin
                out_o <= oc;
                out_inv_o <= ~oc; // [RULE9]
            end else if (mode == `PTMC_MODE_CMP && match_a) begin
                case (io) // [RULE10]
                    2'h1: begin
                        out_o <= 1'b0;
                        out_inv_o <= 1'b1;
                    end
                    2'h2: begin
                        out_o <= 1'b1;
                        out_inv_o <= 1'b0;
                    end
                    2'h3: begin
                        out_o <= ~out_o;
                        out_inv_o <= out_o; // [RULE9]
                    end
                    default: begin
                        out_o <= out_o;
                        out_inv_o <= out_inv_o;
                    end
                endcase
            end else if (mode == `PTMC_MODE_PWM) begin
                // Edge aligned: active from period start until duty match.
                if (io == `PTMC_IO_PWM_OUT || single) begin // [RULE11] [RULE12]
                    out_o <= (run && (count_q < cmp_a_q)) ? ~oc : oc;
                    out_inv_o <= (run && (count_q < cmp_a_q)) ? oc : ~oc; // [RULE9]
                end else begin
                    out_o <= io[0] ? ~oc : oc;
                    out_inv_o <= io[0] ? oc : ~oc; // [RULE9]
                end
            end
            if (wr_i) begin
                case (reg_addr_i)
                    `PTMC_OFS_CTRL0: ctrl0_q <= wdata_i & `PTMC_C0_MASK;
                    `PTMC_OFS_CTRL1: ctrl1_q <= wdata_i;
                    `PTMC_OFS_CMPA_LO, `PTMC_OFS_CMPP_LO: hold_q <= wdata_i; // [RULE16]
                    `PTMC_OFS_CMPA_HI: cmp_a_q <= {wdata_i[1:0], hold_q}; // [RULE17]
                    `PTMC_OFS_CMPP_HI: cmp_p_q <= {wdata_i[1:0], hold_q}; // [RULE17]
                    default: hold_q <= hold_q;
                endcase
            end else if (rd_i) begin
                case (reg_addr_i) // [RULE15] [RULE18]
                    `PTMC_OFS_CNT_HI: hold_q <= count_q[7:0];
                    `PTMC_OFS_CMPA_HI: hold_q <= cmp_a_q[7:0];
                    `PTMC_OFS_CMPP_HI: hold_q <= cmp_p_q[7:0];
                    default: hold_q <= hold_q;
                endcase
            end
            rdata_o <= rd_i ? rd_q : 8'h00;
        end
    end
    always @* begin
        case (reg_addr_i) // [RULE14]
            `PTMC_OFS_CTRL0: rd_q = ctrl0_q;
            `PTMC_OFS_CTRL1: rd_q = ctrl1_q;
            `PTMC_OFS_CNT_HI: rd_q = {6'h00, count_q[9:8]};
            `PTMC_OFS_CMPA_HI: rd_q = {6'h00, cmp_a_q[9:8]};
            `PTMC_OFS_CMPP_HI: rd_q = {6'h00, cmp_p_q[9:8]};
            default: rd_q = hold_q; // [RULE19]
        endcase
    end
endmodule // ptmc_unit

// ### logic/ptmc_top.v
`timescale 1ns/1ps
`include "ptmc_defines.vh"
module ptmc_top (
    // Clock and reset
    input wire ref_clk_i,
    input wire resetn_i,
    // Clock ticks from other oscillators, already on ref_clk_i
    input wire high_clock_tick_i,
    input wire sub_clock_tick_i,
    // Register port
    input wire [4:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    output reg [7:0] reg_rdata_o,
    // Timer pins, index 0 first timer, index 1 second timer
    input wire [1:0] timer_ext_clock_pin_i,
    input wire [1:0] timer_capture_pin_i,
    output wire [1:0] timer_out_pin_o,
    output wire [1:0] timer_out_inv_pin_o,
    output wire [1:0] irq_cmp_a_o,
    output wire [1:0] irq_cmp_p_o
);
    reg [7:0] sys_div_q;
    reg [7:0] hi_div_q;
    reg [1:0] ext_s1_q;
    reg [1:0] ext_s2_q;
    reg [1:0] cap_s1_q;
    reg [1:0] cap_s2_q;
    reg rd_sel_q;
    wire [7:0] unit_rdata [0:1];
    wire tick_div4 = ((sys_div_q & `PTMC_DIV4) == `PTMC_DIV4);
    wire tick_h16 = high_clock_tick_i && ((hi_div_q & `PTMC_DIV16) == `PTMC_DIV16);
    wire tick_h64 = high_clock_tick_i && ((hi_div_q & `PTMC_DIV64) == `PTMC_DIV64);
    always @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sys_div_q <= 8'h00;
            hi_div_q <= 8'h00;
            ext_s1_q <= 2'h0;
            ext_s2_q <= 2'h0;
            cap_s1_q <= 2'h0;
            cap_s2_q <= 2'h0;
            rd_sel_q <= 1'b0;
        end else begin
            sys_div_q <= sys_div_q + 8'h01;
            if (high_clock_tick_i) begin
                hi_div_q <= hi_div_q + 8'h01;
            end
            ext_s1_q <= timer_ext_clock_pin_i; // [RULE25]
            ext_s2_q <= ext_s1_q;
            cap_s1_q <= timer_capture_pin_i; // [RULE25]
            cap_s2_q <= cap_s1_q;
            rd_sel_q <= reg_addr_i[4];
        end
    end
    always @* begin
        reg_rdata_o = unit_rdata[rd_sel_q];
    end
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_unit // [RULE1]
            ptmc_unit u_unit (
                .ref_clk_i(ref_clk_i),
                .resetn_i(resetn_i),
                .tick_div4_i(tick_div4),
                .tick_h16_i(tick_h16),
                .tick_h64_i(tick_h64),
                .tick_sub_i(sub_clock_tick_i),
                .ext_clk_sync_i(ext_s2_q[g]),
                .cap_sync_i(cap_s2_q[g]),
                .reg_addr_i(reg_addr_i[2:0]),
                .wdata_i(reg_wdata_i),
                .wr_i(reg_wr_i && reg_addr_i[4] == g && !reg_addr_i[3]),
                .rd_i(reg_rd_i && reg_addr_i[4] == g && !reg_addr_i[3]),
                .rdata_o(unit_rdata[g]),
                .out_o(timer_out_pin_o[g]),
                .out_inv_o(timer_out_inv_pin_o[g]),
                .irq_a_o(irq_cmp_a_o[g]),
                .irq_p_o(irq_cmp_p_o[g])
            );
        end
    endgenerate
endmodule // ptmc_top

// ### test/ptmc_top_properties.sv
`timescale 1ns/1ps
module ptmc_top_chk (
    // Clock and reset
    input wire ref_clk_i,
    input wire resetn_i,
    // Register port
    input wire [4:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [7:0] reg_rdata_o,
    // Timer pins
    input wire [1:0] timer_out_pin_o,
    input wire [1:0] timer_out_inv_pin_o,
    input wire [1:0] irq_cmp_a_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    sequence s_wr(a);
        reg_wr_i && reg_addr_i == a;
    endsequence
    sequence s_rd(a);
        reg_rd_i && reg_addr_i == a;
    endsequence
    chk_inv_complement: assert property (timer_out_inv_pin_o == ~timer_out_pin_o)
        else $error("inverted pin is not the complement");
    chk_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
        else $error("read data outside its cycle");
    chk_high_byte_width: assert property (reg_rd_i && !reg_addr_i[3] && reg_addr_i[0]
        && reg_addr_i[2:1] != 2'b00 |=> reg_rdata_o[7:2] == 6'h00)
        else $error("high byte wider than two bits");
    chk_unmapped_zero: assert property (reg_rd_i && reg_addr_i[3] |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    chk_high_write_read: assert property (s_wr(5'h07) ##1 s_rd(5'h07) |=>
        reg_rdata_o[1:0] == $past(reg_wdata_i[1:0], 2) && reg_rdata_o[7:2] == 6'h00)
        else $error("high byte readback wrong");
    chk_pair_atomic: assert property (s_wr(5'h06) ##1 s_wr(5'h07) ##1 s_rd(5'h07)
        ##2 s_rd(5'h06) |=> reg_rdata_o == $past(reg_wdata_i, 5))
        else $error("low byte not loaded with high write");
    chk_low_write_buffered: assert property (s_wr(5'h04) ##1 s_wr(5'h05) ##1 s_wr(5'h04)
        ##1 s_rd(5'h05) ##2 s_rd(5'h04) |=> reg_rdata_o == $past(reg_wdata_i, 6))
        else $error("low write reached the live value");
    chk_irq_pulse: assert property (irq_cmp_a_o[0] |=> !irq_cmp_a_o[0])
        else $error("interrupt longer than one cycle");
endmodule // ptmc_top_chk
bind ptmc_top ptmc_top_chk ptmc_top_chk_inst (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .timer_out_pin_o(timer_out_pin_o),
    .timer_out_inv_pin_o(timer_out_inv_pin_o), .irq_cmp_a_o(irq_cmp_a_o)
);

// ### test/ptmc_cpu_model.sv
`timescale 1ns/1ps
module ptmc_cpu_model (
    // Clock
    input wire logic ref_clk_i,
    // Register port
    output logic [4:0] reg_addr_o = 5'h00,
    output logic [7:0] reg_wdata_o = 8'h00,
    output logic reg_wr_o = 1'b0,
    output logic reg_rd_o = 1'b0,
    input wire logic [7:0] reg_rdata_i
);
    // Callers write low before high and read high before low.
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        reg_addr_o <= a;
        reg_wdata_o <= d;
        reg_wr_o <= 1'b1;
        reg_rd_o <= 1'b0;
        @(posedge ref_clk_i);
    endtask
    // The data stand only in the cycle after the strobe, so a read costs two cycles.
    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        reg_addr_o <= a;
        reg_rd_o <= 1'b1;
        reg_wr_o <= 1'b0;
        @(posedge ref_clk_i);
        reg_rd_o <= 1'b0;
        @(posedge ref_clk_i);
        d = reg_rdata_i;
    endtask
    task automatic idle();
        reg_wr_o <= 1'b0;
        reg_rd_o <= 1'b0;
        @(posedge ref_clk_i);
    endtask
endmodule // ptmc_cpu_model

// ### test/test_ptmc_top.sv
`timescale 1ns/1ps
module test_ptmc_top;
    logic ref_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic hi_tick = 1'b0;
    logic sub_tick = 1'b0;
    // The pins are taken as already routed to the timer by the pin-sharing setup.
    logic [1:0] ext_pin = 2'b00;
    logic [1:0] cap_pin = 2'b00;
    wire [4:0] addr;
    wire [7:0] wdata;
    wire [7:0] rdata;
    wire wr_s;
    wire rd_s;
    wire [1:0] out;
    wire [1:0] out_inv;
    wire [1:0] irq_a;
    wire [1:0] irq_p;
    int n_mismatch = 0;
    int cmp_count = 0;
    int n_irq_a = 0;
    int n_irq_p = 0;
    int n_tog = 0;
    int n_hi = 0;
    int tsel = 0;
    logic out_q = 1'b0;
    logic [7:0] d;
    initial begin
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end
    ptmc_cpu_model ptmc_cpu_model_inst (.ref_clk_i(ref_clk_i), .reg_addr_o(addr),
        .reg_wdata_o(wdata), .reg_wr_o(wr_s), .reg_rd_o(rd_s), .reg_rdata_i(rdata));
    ptmc_top ptmc_top_inst (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
        .high_clock_tick_i(hi_tick), .sub_clock_tick_i(sub_tick), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdata),
        .timer_ext_clock_pin_i(ext_pin), .timer_capture_pin_i(cap_pin),
        .timer_out_pin_o(out), .timer_out_inv_pin_o(out_inv),
        .irq_cmp_a_o(irq_a), .irq_cmp_p_o(irq_p));
    // Tick inputs run so the divided clock paths see activity.
    always @(posedge ref_clk_i) begin
        hi_tick <= ~hi_tick;
        sub_tick <= ~sub_tick;
        if (irq_a[tsel] === 1'b1) n_irq_a++;
        if (irq_p[tsel] === 1'b1) n_irq_p++;
        if (out[tsel] !== out_q) n_tog++;
        if (out[tsel] === 1'b1) n_hi++;
        out_q <= out[tsel];
    end
    task automatic wr(input logic [4:0] a, input logic [7:0] v);
        ptmc_cpu_model_inst.wr(a, v);
    endtask
    task automatic rd(input logic [4:0] a);
        ptmc_cpu_model_inst.rd(a, d);
    endtask
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Counters are cleared off the edge so they never race the counting process.
    task automatic setup(input logic t, input logic [7:0] c1, input logic [9:0] a, p,
        input logic [7:0] c0);
        wr({t, 4'h0}, 8'h00);
        wr({t, 4'h1}, c1);
        wr({t, 4'h4}, a[7:0]);
        wr({t, 4'h5}, {6'h00, a[9:8]});
        wr({t, 4'h6}, p[7:0]);
        wr({t, 4'h7}, {6'h00, p[9:8]});
        wr({t, 4'h0}, c0);
        ptmc_cpu_model_inst.idle();
        #1;
        tsel = t;
        n_irq_a = 0;
        n_irq_p = 0;
        n_tog = 0;
        n_hi = 0;
    endtask
    task automatic stop(input logic t);
        wr({t, 4'h0}, 8'h10);
        ptmc_cpu_model_inst.idle();
        repeat (4) @(posedge ref_clk_i);
    endtask
    initial begin
        #50000;
        n_mismatch++;
        end_sim();
    end
    initial begin
        repeat (10) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        @(posedge ref_clk_i);
        cmp8({6'h00, out_inv}, 8'h03);
        for (int t = 0; t < 2; t++) begin
            wr({t[0], 4'h4}, {7'h1a, t[0]});
            wr({t[0], 4'h5}, 8'h01);
            wr({t[0], 4'h4}, 8'h5a);
            rd({t[0], 4'h5}); cmp8(d, 8'h01);
            rd({t[0], 4'h4}); cmp8(d, {7'h1a, t[0]});
            wr({t[0], 4'h6}, 8'h7f);
            wr({t[0], 4'h7}, 8'h02);
            rd({t[0], 4'h7}); cmp8(d, 8'h02);
            rd({t[0], 4'h6}); cmp8(d, 8'h7f);
            rd({t[0], 4'h8}); cmp8(d, 8'h00);
        end
        setup(1'b1, 8'h31, 10'h004, 10'h3ff, 8'h18);
        repeat (52) @(posedge ref_clk_i);
        stop(1'b1);
        cmp8(8'(n_tog), 8'(n_irq_a));
        cmp8({7'h00, out[1]}, {7'h00, n_tog[0]});
        cmp8(8'(n_irq_a > 9 && n_irq_a < 12), 8'h01);
        cmp8(8'(n_irq_p), 8'h00);
        setup(1'b0, 8'hc0, 10'h003, 10'h009, 8'h18);
        repeat (100) @(posedge ref_clk_i);
        stop(1'b0);
        cmp8(8'(n_irq_a), 8'(n_irq_p));
        cmp8(8'(n_irq_p > 8 && n_irq_p < 12), 8'h01);
        cmp8({6'h00, out}, 8'h00);
        for (int i = 0; i < 2; i++) begin
            setup(1'b0, 8'h00, 10'h002, 10'h3ff, i ? 8'h78 : 8'h68);
            repeat (3) begin
                ext_pin[0] <= 1'b1;
                repeat (8) @(posedge ref_clk_i);
                ext_pin[0] <= 1'b0;
                repeat (8) @(posedge ref_clk_i);
            end
            cmp8(8'(n_irq_a), 8'h01);
            rd(5'h03); cmp8(d, 8'h00);
            rd(5'h02); cmp8(d, 8'h03);
        end
        // Capture on the dedicated pin, rising only, then on the clock pin, both edges.
        for (int i = 0; i < 2; i++) begin
            setup(1'b1, i ? 8'h62 : 8'h40, 10'h000, 10'h3ff, 8'h18);
            @(posedge ref_clk_i);
            if (i) ext_pin[1] <= 1'b1;
            else cap_pin[1] <= 1'b1;
            repeat (10) @(posedge ref_clk_i);
            if (i) ext_pin[1] <= 1'b0;
            else cap_pin[1] <= 1'b0;
            repeat (8) @(posedge ref_clk_i);
            rd(5'h15); cmp8(d, 8'h00);
            rd(5'h14); cmp8(d, i ? 8'h0d : 8'h03);
            stop(1'b1);
        end
        setup(1'b0, 8'ha0, 10'h002, 10'h009, 8'h18);
        repeat (100) @(posedge ref_clk_i);
        stop(1'b0);
        cmp8(8'(n_hi > 17 && n_hi < 23), 8'h01);
        cmp8(8'(n_tog > 17 && n_tog < 24), 8'h01);
        cmp8(8'(n_irq_p > 8 && n_irq_p < 12), 8'h01);
        cmp8({7'h00, out[0]}, 8'h00);
        setup(1'b0, 8'hb0, 10'h002, 10'h005, 8'h18);
        repeat (20) @(posedge ref_clk_i);
        cmp8(8'(n_hi), 8'h00);
        ext_pin[0] <= 1'b1;
        repeat (20) @(posedge ref_clk_i);
        ext_pin[0] <= 1'b0;
        stop(1'b0);
        cmp8(8'(n_hi), 8'h02);
        cmp8(8'(n_irq_p), 8'h01);
        end_sim();
    end
endmodule // test_ptmc_top
